// ### rtl/halt_idle_pkg.sv
// Holds constants, register offsets, modes and carrier structs for the standby controller.
// Assumes a 25 MHz core clock and a classic Wishbone register bus.
package halt_idle_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_WRITE_PROTECT_CMD = 4'h0;
  localparam logic [3:0] ADDR_POWER_SAVE_CTRL = 4'h4;
  localparam logic [3:0] ADDR_POWER_SAVE_MODE = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hC;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_STANDBY_BIT = 1;
  localparam int CTRL_NMI_MASK_BIT = 4;
  localparam int CTRL_INT_MASK_BIT = 5;
  localparam int MODE_IDLE_BIT = 0;

  // ---------------------------------------------------------------
  // Reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int NUM_IRQ = 32;
  localparam int PRIO_W = 3;
  localparam logic [PRIO_W:0] PRIO_NONE = 4'h8;
  localparam logic [PRIO_W:0] PRIO_NMI = 4'h0;
  localparam logic [NUM_IRQ-1:0] IDLE_WAKE_LINES = 32'h03F0001F;
  localparam logic [NUM_IRQ-1:0] FILTERABLE_LINES = 32'h03F00000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int IDLE_RESUME_NS = 40;
  localparam int IDLE_RESUME_CYC =
    (IDLE_RESUME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_IDLE = 2'b10,
    ST_RESUME = 2'b11
  } pwr_state_t;

  typedef struct packed {
    logic nmi;
    logic [NUM_IRQ-1:0] req;
    logic [NUM_IRQ-1:0] unmasked;
    logic [NUM_IRQ-1:0] dig_filter;
  } irq_in_t;

  typedef struct packed {
    logic in_isr;
    logic in_nmi_isr;
    logic [PRIO_W-1:0] cur_prio;
    logic irq_enabled_state;
    logic halt_insn;
  } cpu_in_t;

  typedef struct packed {
    logic wake_ack;
    logic wake_pending;
    logic wake_branch;
    logic wake_continue;
  } wake_out_t;

endpackage

// ### rtl/irq_prio_table.sv
// Holds the priority level of each maskable request in a small register file.
// Assumes software loads priorities once; read data comes out of a register.
module irq_prio_table (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [2:0] wr_prio,
  output logic [3*halt_idle_pkg::NUM_IRQ-1:0] prio_flat
);

  logic [3*halt_idle_pkg::NUM_IRQ-1:0] prio_ff;
  logic [3*halt_idle_pkg::NUM_IRQ-1:0] nxt_prio;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < halt_idle_pkg::NUM_IRQ; g++) begin : g_ent
      always_comb begin
        nxt_prio[3*g +: 3] = prio_ff[3*g +: 3];
        if (wr_en && wr_idx == 5'(g)) begin
          nxt_prio[3*g +: 3] = wr_prio;
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      prio_ff <= '1;
    end else begin
      prio_ff <= nxt_prio;
    end
  end

  assign prio_flat = prio_ff;

endmodule

// ### rtl/halt_idle_wakeup_control.sv
// Holds the HALT/IDLE standby controller: mode entry, clock gating and wake-up.
// Assumes the CPU core reports its interrupt context and the interrupt controller
// supplies levels on the core clock; the reset pin is synchronised here.
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.

// Notes on behaviour
// R1 - Non-maskable, unmasked maskable or reset pin input ends HALT.
// R2 - In an ISR, lower priority request ends HALT but stays pending.
// R3 - In an ISR, higher priority request or NMI ends HALT and is acknowledged.
// R4 - After wake NMI branches; maskable branches if enabled, else continues.
// R5 - Reset pin exit behaves as an ordinary device reset.
// R6 - IDLE keeps oscillator running but gates all internal system clocks.
// R7 - Leaving IDLE resumes promptly without stabilisation or lock wait.
// R8 - Software requests IDLE by writing control or mode register; code needs a protected control write, mode IDLE bit already set.
// R9 - IDLE stops execution and keeps registers, RAM and port outputs.
// R10 - IDLE stops peripherals except both serial ports in slave mode.
// R11 - IDLE ends on NMI, unmasked inputs 0-4 or 20-25, or reset pin.
// R12 - Inputs 20-25 with digital filter selected never wake IDLE.
// R13 - Interrupt wake from IDLE only if both mask bits were 0 at entry.
// R14 - In maskable ISR, lower priority request ends IDLE but stays pending.
// R15 - In maskable ISR, higher priority request ends IDLE, acknowledged at once.
// R16 - In NMI ISR, any wake request ends IDLE but stays pending.
// R17 - Software sets a flag before IDLE to tell NMI wake from ordinary NMI.
// R18 - HALT stops only the CPU clock; peripherals keep running.
// R19 - Protect command write must be followed directly by control write.
// R20 - Software runs five no-ops after the control write entering IDLE.
// R21 - System clock gate switches synchronously and glitch free.
module halt_idle_wakeup_control (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic RESET_PIN_N,
  input wire halt_idle_pkg::irq_in_t IRQ_IN,
  input wire halt_idle_pkg::cpu_in_t CPU_IN,
  input wire logic SERIAL_A_SLAVE,
  input wire logic SERIAL_B_SLAVE,
  output halt_idle_pkg::wake_out_t WAKE_OUT,
  output logic CPU_CLK_EN,
  output logic SYS_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic SERIAL_A_CLK_EN,
  output logic SERIAL_B_CLK_EN,
  output logic OSC_PLL_RUN,
  output logic RESET_OUT
);

  halt_idle_pkg::pwr_state_t state_ff, nxt_state;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] mode_ff, nxt_mode;
  logic unlock_ff, nxt_unlock;
  logic intwake_ok_ff, nxt_intwake_ok;
  logic ack_ff, nxt_ack;
  logic [2:0] rst_sync_ff;
  logic rst_ff, nxt_rst;
  halt_idle_pkg::wake_out_t wake_ff, nxt_wake;
  logic gate_cpu_ff, nxt_gate_cpu;
  logic gate_sys_ff, nxt_gate_sys;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [3*halt_idle_pkg::NUM_IRQ-1:0] prio_flat;
  logic [halt_idle_pkg::NUM_IRQ-1:0] wake_lines;
  logic [halt_idle_pkg::NUM_IRQ-1:0] above_cur;
  logic maskable_wake, any_wake, higher_wake, bus_req, wr_ctrl, idle_req;

  // ---------------------------------------------------------------
  // Reset pin synchroniser
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rst = rst_ff;
    if (rst_sync_ff[1] == rst_sync_ff[2]) begin
      nxt_rst = ~rst_sync_ff[2];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rst_sync_ff <= 3'h7;
      rst_ff <= 1'b0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[1:0], RESET_PIN_N};
      rst_ff <= nxt_rst;
    end
  end

  // Pin reset is a plain device reset, no wake bookkeeping [R5]
  assign RESET_OUT = rst_ff;

  // ---------------------------------------------------------------
  // Priority table, loaded through the status offset by writes
  // ---------------------------------------------------------------
  irq_prio_table irq_prio_table_i (
    .CORE_CLK(CORE_CLK),
    .SRST(SRST || rst_ff), // [R5]
    .wr_en(bus_req && WB_WE_I && !WB_ACK_O && WB_ADR_I == halt_idle_pkg::ADDR_STATUS),
    .wr_idx(WB_DAT_I[12:8]),
    .wr_prio(WB_DAT_I[2:0]),
    .prio_flat(prio_flat)
  );

  // ---------------------------------------------------------------
  // Wake qualification
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < halt_idle_pkg::NUM_IRQ; g++) begin : g_line
      always_comb begin
        wake_lines[g] = IRQ_IN.req[g] && IRQ_IN.unmasked[g];
        if (state_ff == halt_idle_pkg::ST_IDLE) begin
          // Only the documented external inputs reach the IDLE waker [R11]
          // Clock-sampled filters are asleep with the system clock [R12]
          wake_lines[g] = wake_lines[g] && halt_idle_pkg::IDLE_WAKE_LINES[g] &&
            !(halt_idle_pkg::FILTERABLE_LINES[g] && IRQ_IN.dig_filter[g]);
        end
        above_cur[g] = prio_flat[3*g +: 3] < CPU_IN.cur_prio;
      end
    end
  endgenerate

  assign maskable_wake = |wake_lines;
  assign any_wake = IRQ_IN.nmi || maskable_wake;
  // NMI outranks any maskable routine; nothing outranks the NMI routine
  assign higher_wake = !CPU_IN.in_nmi_isr &&
    (IRQ_IN.nmi || !CPU_IN.in_isr || |(wake_lines & above_cur));

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  assign bus_req = WB_CYC_I && WB_STB_I;
  assign wr_ctrl = bus_req && WB_WE_I && !WB_ACK_O && WB_SEL_I[0] &&
    WB_ADR_I == halt_idle_pkg::ADDR_POWER_SAVE_CTRL;
  assign idle_req = wr_ctrl && unlock_ff && WB_DAT_I[halt_idle_pkg::CTRL_STANDBY_BIT] &&
    mode_ff[halt_idle_pkg::MODE_IDLE_BIT];

  always_comb begin
    nxt_ack = bus_req && !WB_ACK_O;
    nxt_ctrl = ctrl_ff;
    nxt_mode = mode_ff;
    nxt_unlock = unlock_ff;
    nxt_rdata = rdata_ff;
    if (bus_req && !WB_ACK_O) begin
      nxt_rdata = 32'h0000_0000;
      // Any other store breaks the protect sequence [R19]
      nxt_unlock = 1'b0;
      if (WB_WE_I) begin
        if (WB_ADR_I == halt_idle_pkg::ADDR_WRITE_PROTECT_CMD) begin
          nxt_unlock = 1'b1;
        end else if (WB_ADR_I == halt_idle_pkg::ADDR_POWER_SAVE_CTRL) begin
          if (unlock_ff && WB_SEL_I[0]) begin
            nxt_ctrl = WB_DAT_I[7:0];
          end
        end else if (WB_ADR_I == halt_idle_pkg::ADDR_POWER_SAVE_MODE) begin
          // Mode register needs no protect step [R8]
          if (WB_SEL_I[0]) begin
            nxt_mode = WB_DAT_I[7:0];
          end
        end
      end else begin
        if (WB_ADR_I == halt_idle_pkg::ADDR_POWER_SAVE_CTRL) begin
          nxt_rdata = {24'h000000, ctrl_ff};
        end else if (WB_ADR_I == halt_idle_pkg::ADDR_POWER_SAVE_MODE) begin
          nxt_rdata = {24'h000000, mode_ff};
        end else if (WB_ADR_I == halt_idle_pkg::ADDR_STATUS) begin
          nxt_rdata = {28'h0000000, intwake_ok_ff, gate_sys_ff, 2'(state_ff)};
        end
      end
    end
    // Standby bit clears itself when standby ends
    if (state_ff == halt_idle_pkg::ST_RESUME) begin
      nxt_ctrl[halt_idle_pkg::CTRL_STANDBY_BIT] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Power state machine
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_intwake_ok = intwake_ok_ff;
    nxt_wake = '0;
    case (state_ff)
      halt_idle_pkg::ST_RUN: begin
        if (idle_req) begin
          nxt_state = halt_idle_pkg::ST_IDLE;
          // Masks are latched at entry, later writes cannot change this [R13]
          nxt_intwake_ok = !WB_DAT_I[halt_idle_pkg::CTRL_INT_MASK_BIT] &&
            !WB_DAT_I[halt_idle_pkg::CTRL_NMI_MASK_BIT];
        end else if (CPU_IN.halt_insn) begin
          nxt_state = halt_idle_pkg::ST_HALT;
        end
      end
      halt_idle_pkg::ST_HALT: begin
        if (any_wake) begin // [R1]
          nxt_state = halt_idle_pkg::ST_RESUME;
          nxt_wake.wake_ack = higher_wake; // [R3]
          nxt_wake.wake_pending = !higher_wake; // [R2]
        end
      end
      halt_idle_pkg::ST_IDLE: begin
        if (any_wake && intwake_ok_ff) begin // [R11] [R13]
          nxt_state = halt_idle_pkg::ST_RESUME;
          nxt_wake.wake_ack = higher_wake; // [R15]
          nxt_wake.wake_pending = !higher_wake; // [R14] [R16]
        end
      end
      halt_idle_pkg::ST_RESUME: begin
        // One cycle to restart the gate, no oscillator wait [R7]
        nxt_state = halt_idle_pkg::ST_RUN;
      end
      default: begin
        nxt_state = halt_idle_pkg::ST_RUN;
      end
    endcase
    if (state_ff == halt_idle_pkg::ST_HALT || state_ff == halt_idle_pkg::ST_IDLE) begin
      if (any_wake && (state_ff == halt_idle_pkg::ST_HALT || intwake_ok_ff)) begin
        // NMI branches when acknowledged; maskable also needs the enable state [R4]
        nxt_wake.wake_branch = IRQ_IN.nmi ? nxt_wake.wake_ack :
          (CPU_IN.irq_enabled_state && nxt_wake.wake_ack);
        nxt_wake.wake_continue = !nxt_wake.wake_branch;
      end
    end
  end

  // ---------------------------------------------------------------
  // Clock gates, registered so they switch only on the rising CORE_CLK edge [R21]
  // ---------------------------------------------------------------
  always_comb begin
    // HALT stops only the CPU clock [R18]
    nxt_gate_cpu = nxt_state == halt_idle_pkg::ST_RUN;
    // IDLE stops the system and peripheral clocks; slave serial ports keep theirs [R6] [R9]
    nxt_gate_sys = nxt_state != halt_idle_pkg::ST_IDLE;
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST || rst_ff) begin
      state_ff <= halt_idle_pkg::ST_RUN;
      ctrl_ff <= halt_idle_pkg::CTRL_RESET;
      mode_ff <= halt_idle_pkg::MODE_RESET;
      unlock_ff <= 1'b0;
      intwake_ok_ff <= 1'b0;
      wake_ff <= '0;
      gate_cpu_ff <= 1'b1;
      gate_sys_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      ack_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ctrl_ff <= nxt_ctrl;
      mode_ff <= nxt_mode;
      unlock_ff <= nxt_unlock;
      intwake_ok_ff <= nxt_intwake_ok;
      wake_ff <= nxt_wake;
      gate_cpu_ff <= nxt_gate_cpu;
      gate_sys_ff <= nxt_gate_sys;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdata_ff;
  assign WAKE_OUT = wake_ff;
  assign CPU_CLK_EN = gate_cpu_ff;
  assign SYS_CLK_EN = gate_sys_ff;
  assign PERIPH_CLK_EN = gate_sys_ff;
  // Slave serial ports run off the partner's clock through IDLE [R10]
  assign SERIAL_A_CLK_EN = gate_sys_ff || SERIAL_A_SLAVE;
  assign SERIAL_B_CLK_EN = gate_sys_ff || SERIAL_B_SLAVE;
  // Oscillator and PLL never stop in these modes [R6]
  assign OSC_PLL_RUN = 1'b1;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_in_idle;
    state_ff == halt_idle_pkg::ST_IDLE;
  endsequence

  sequence s_resume_run;
    state_ff == halt_idle_pkg::ST_RESUME ##1 state_ff == halt_idle_pkg::ST_RUN;
  endsequence

  property p_halt_exit;
    @(posedge CORE_CLK) disable iff (SRST || rst_ff)
      (state_ff == halt_idle_pkg::ST_HALT && any_wake) |=> s_resume_run;
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("HALT not left on wake"); // [R1]

  property p_low_pending;
    @(posedge CORE_CLK) disable iff (SRST || rst_ff)
      (state_ff == halt_idle_pkg::ST_HALT && any_wake && !higher_wake)
        |=> WAKE_OUT.wake_pending && !WAKE_OUT.wake_ack;
  endproperty
  a_low_pending: assert property (p_low_pending) else $error("Low request acked"); // [R2]

  property p_high_ack;
    @(posedge CORE_CLK) disable iff (SRST || rst_ff)
      (state_ff != halt_idle_pkg::ST_RUN && state_ff != halt_idle_pkg::ST_RESUME &&
       nxt_state == halt_idle_pkg::ST_RESUME && higher_wake) |=> WAKE_OUT.wake_ack;
  endproperty
  a_high_ack: assert property (p_high_ack) else $error("High request not acked"); // [R3]

  property p_branch;
    @(posedge CORE_CLK) disable iff (SRST || rst_ff)
      WAKE_OUT.wake_branch |-> WAKE_OUT.wake_ack && !WAKE_OUT.wake_continue;
  endproperty
  a_branch: assert property (p_branch) else $error("Branch without ack"); // [R4]

  property p_idle_gate;
    @(posedge CORE_CLK) disable iff (SRST || rst_ff)
      s_in_idle |-> !SYS_CLK_EN && !CPU_CLK_EN && OSC_PLL_RUN;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("Clock live in IDLE"); // [R6]

  property p_prompt;
    @(posedge CORE_CLK) disable iff (SRST || rst_ff)
      state_ff == halt_idle_pkg::ST_RESUME |=> state_ff == halt_idle_pkg::ST_RUN && SYS_CLK_EN;
  endproperty
  a_prompt: assert property (p_prompt) else $error("Slow IDLE resume"); // [R7]

  property p_masked;
    @(posedge CORE_CLK) disable iff (SRST || rst_ff)
      (s_in_idle and !intwake_ok_ff) |=> s_in_idle;
  endproperty
  a_masked: assert property (p_masked) else $error("Masked wake left IDLE"); // [R13]

  property p_halt_periph;
    @(posedge CORE_CLK) disable iff (SRST || rst_ff)
      state_ff == halt_idle_pkg::ST_HALT |-> PERIPH_CLK_EN && !CPU_CLK_EN;
  endproperty
  a_halt_periph: assert property (p_halt_periph) else $error("HALT gating wrong"); // [R18]

  property p_serial;
    @(posedge CORE_CLK) disable iff (SRST || rst_ff)
      (s_in_idle and SERIAL_A_SLAVE) |-> SERIAL_A_CLK_EN && !PERIPH_CLK_EN;
  endproperty
  a_serial: assert property (p_serial) else $error("Slave serial stopped"); // [R10]

  property p_nmi_isr;
    @(posedge CORE_CLK) disable iff (SRST || rst_ff)
      (s_in_idle and intwake_ok_ff && any_wake && CPU_IN.in_nmi_isr) |=> WAKE_OUT.wake_pending;
  endproperty
  a_nmi_isr: assert property (p_nmi_isr) else $error("NMI routine wake acked"); // [R16]

endmodule

// ### tb/wake_partner_model.sv
// Holds a behavioural model of the CPU context and the interrupt controller.
// Assumes the bench calls its tasks; every change lands just after a rising edge.
module wake_partner_model (
  input wire logic clk,
  output halt_idle_pkg::irq_in_t irq_out,
  output halt_idle_pkg::cpu_in_t cpu_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    irq_out = '0;
    cpu_out = '0;
  end

  task automatic set_ctx(input logic isr, input logic nisr, input logic [2:0] pr,
    input logic ei);
    @(posedge clk);
    cpu_out.in_isr <= isr;
    cpu_out.in_nmi_isr <= nisr;
    cpu_out.cur_prio <= pr;
    cpu_out.irq_enabled_state <= ei;
  endtask

  // Requests stay up as levels; pending ones are not withdrawn
  task automatic raise(input int line, input logic unm, input logic filt);
    @(posedge clk);
    irq_out.req[line] <= 1'b1;
    irq_out.unmasked[line] <= unm;
    irq_out.dig_filter[line] <= filt;
  endtask

  task automatic raise_nmi();
    @(posedge clk);
    irq_out.nmi <= 1'b1;
  endtask

  task automatic drop();
    @(posedge clk);
    irq_out <= '0;
  endtask

  task automatic halt();
    @(posedge clk);
    cpu_out.halt_insn <= 1'b1;
    @(posedge clk);
    cpu_out.halt_insn <= 1'b0;
  endtask
endmodule

// ### tb/halt_idle_wakeup_control_tb.sv
// Holds the self-checking bench of the standby controller.
// Assumes one 25 MHz clock, a classic Wishbone master and the partner model.
module halt_idle_wakeup_control_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic pin_n = 1'b1;
  logic sla = 1'b0;
  logic slb = 1'b0;
  halt_idle_pkg::irq_in_t irq;
  halt_idle_pkg::cpu_in_t cpu;
  halt_idle_pkg::wake_out_t wake;
  logic cpu_en, sys_en, per_en, sa_en, sb_en, osc, rst_out;
  logic [31:0] rd;
  logic [3:0] w;
  int fail_count = 0;
  int compares = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  wake_partner_model wake_partner_model_i (.clk(clk), .irq_out(irq), .cpu_out(cpu));

  halt_idle_wakeup_control halt_idle_wakeup_control_i (
    .CORE_CLK(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .RESET_PIN_N(pin_n), .IRQ_IN(irq), .CPU_IN(cpu), .SERIAL_A_SLAVE(sla),
    .SERIAL_B_SLAVE(slb), .WAKE_OUT(wake), .CPU_CLK_EN(cpu_en), .SYS_CLK_EN(sys_en),
    .PERIPH_CLK_EN(per_en), .SERIAL_A_CLK_EN(sa_en), .SERIAL_B_CLK_EN(sb_en),
    .OSC_PLL_RUN(osc), .RESET_OUT(rst_out));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Wishbone classic master
  // ---------------------------------------------------------------
  task automatic wb_cycle(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  // Waits a bounded span for a wake pulse; zero when none came
  task automatic wait_wake();
    w = 4'h0;
    for (int i = 0; i < 8 && w == 4'h0; i++) begin
      @(negedge clk);
      w = wake;
    end
  endtask

  // Caller's software keeps its own NMI-from-IDLE flag outside this block
  task automatic enter_idle(input logic [7:0] ctrl);
    wb_cycle(1'b1, halt_idle_pkg::ADDR_POWER_SAVE_MODE, 32'h01);
    wb_cycle(1'b1, halt_idle_pkg::ADDR_WRITE_PROTECT_CMD, 32'hA5);
    wb_cycle(1'b1, halt_idle_pkg::ADDR_POWER_SAVE_CTRL, {24'h0, ctrl});
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check({cpu_en, sys_en, osc, rst_out}, 32'hE);
    wb_cycle(1'b0, halt_idle_pkg::ADDR_POWER_SAVE_CTRL, 32'h0);
    check(rd, 32'h0);
    wb_cycle(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    wb_cycle(1'b0, halt_idle_pkg::ADDR_STATUS, 32'h0);
    check(rd[2:0], 32'h4);
  endtask

  // Control write not preceded by the protect command is dropped
  task automatic t_lock();
    wb_cycle(1'b1, halt_idle_pkg::ADDR_POWER_SAVE_MODE, 32'h01);
    wb_cycle(1'b1, halt_idle_pkg::ADDR_POWER_SAVE_CTRL, 32'h02);
    repeat (5) @(negedge clk);
    check(sys_en, 32'h1);
    wb_cycle(1'b0, halt_idle_pkg::ADDR_POWER_SAVE_CTRL, 32'h0);
    check(rd, 32'h0);
  endtask

  task automatic t_halt();
    wake_partner_model_i.halt();
    @(negedge clk);
    check({cpu_en, sys_en, per_en, osc}, 32'h7);
    wake_partner_model_i.raise(3, 1'b0, 1'b0);
    wait_wake();
    check(w, 32'h0);
    wake_partner_model_i.raise_nmi();
    wait_wake();
    check(w, 32'hA);
    @(negedge clk);
    check(cpu_en, 32'h1);
    wake_partner_model_i.drop();
  endtask

  task automatic t_halt_isr();
    wb_cycle(1'b1, halt_idle_pkg::ADDR_STATUS, 32'h0601);
    wake_partner_model_i.set_ctx(1'b1, 1'b0, 3'h3, 1'b1);
    wake_partner_model_i.halt();
    wake_partner_model_i.raise(5, 1'b1, 1'b0);
    wait_wake();
    check(w[3:2], 32'h1);
    wake_partner_model_i.drop();
    wake_partner_model_i.halt();
    wake_partner_model_i.raise(6, 1'b1, 1'b0);
    wait_wake();
    check(w[3:2], 32'h2);
    wake_partner_model_i.drop();
    wake_partner_model_i.halt();
    wake_partner_model_i.raise_nmi();
    wait_wake();
    check(w[3:2], 32'h2);
    wake_partner_model_i.drop();
    wake_partner_model_i.set_ctx(1'b0, 1'b0, 3'h0, 1'b0);
    wake_partner_model_i.halt();
    wake_partner_model_i.raise(7, 1'b1, 1'b0);
    wait_wake();
    check(w[1:0], 32'h1);
    wake_partner_model_i.drop();
  endtask

  task automatic t_idle();
    sla <= 1'b1;
    wake_partner_model_i.set_ctx(1'b0, 1'b0, 3'h0, 1'b1);
    enter_idle(8'h02);
    check({cpu_en, sys_en, per_en, osc}, 32'h1);
    check({sa_en, sb_en}, 32'h2);
    @(posedge clk);
    slb <= 1'b1;
    @(negedge clk);
    check(sb_en, 32'h1);
    wake_partner_model_i.raise(8, 1'b1, 1'b0);
    wait_wake();
    check(w, 32'h0);
    wake_partner_model_i.raise(21, 1'b1, 1'b1);
    wait_wake();
    check(w, 32'h0);
    wake_partner_model_i.raise(21, 1'b1, 1'b0);
    wait_wake();
    check(w[3], 32'h1);
    @(negedge clk);
    check({cpu_en, sys_en}, 32'h3);
    wake_partner_model_i.drop();
    wb_cycle(1'b0, halt_idle_pkg::ADDR_POWER_SAVE_CTRL, 32'h0);
    check(rd[1], 32'h0);
  endtask

  task automatic t_idle_isr();
    wb_cycle(1'b1, halt_idle_pkg::ADDR_STATUS, 32'h0001);
    wake_partner_model_i.set_ctx(1'b1, 1'b0, 3'h3, 1'b1);
    enter_idle(8'h02);
    wake_partner_model_i.raise(4, 1'b1, 1'b0);
    wait_wake();
    check(w[3:2], 32'h1);
    wake_partner_model_i.drop();
    enter_idle(8'h02);
    wake_partner_model_i.raise(0, 1'b1, 1'b0);
    wait_wake();
    check(w[3:2], 32'h2);
    wake_partner_model_i.drop();
    enter_idle(8'h02);
    wake_partner_model_i.raise_nmi();
    wait_wake();
    check(w, 32'hA);
    wake_partner_model_i.drop();
    wake_partner_model_i.set_ctx(1'b1, 1'b1, 3'h0, 1'b1);
    enter_idle(8'h02);
    wake_partner_model_i.raise(2, 1'b1, 1'b0);
    wait_wake();
    check(w[3:2], 32'h1);
    wake_partner_model_i.drop();
  endtask

  // Masked entry, then the reset pin as the only way out
  task automatic t_mask();
    wake_partner_model_i.set_ctx(1'b0, 1'b0, 3'h0, 1'b1);
    enter_idle(8'h32);
    wake_partner_model_i.raise_nmi();
    wake_partner_model_i.raise(1, 1'b1, 1'b0);
    wait_wake();
    check(w, 32'h0);
    check(sys_en, 32'h0);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (6) @(negedge clk);
    check({rst_out, cpu_en, sys_en}, 32'h7);
    wake_partner_model_i.drop();
    @(posedge clk);
    pin_n <= 1'b1;
    repeat (6) @(negedge clk);
    check(rst_out, 32'h0);
    wb_cycle(1'b0, halt_idle_pkg::ADDR_POWER_SAVE_MODE, 32'h0);
    check(rd, 32'h0);
    // Pin reset restores the priority table too, so line 0 is low again
    wake_partner_model_i.set_ctx(1'b1, 1'b0, 3'h3, 1'b1);
    wake_partner_model_i.halt();
    wake_partner_model_i.raise(0, 1'b1, 1'b0);
    wait_wake();
    check(w[3:2], 32'h1);
    wake_partner_model_i.drop();
  endtask

  initial begin
    #(40 * 6000);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_lock();
    t_halt();
    t_halt_isr();
    t_idle();
    t_idle_isr();
    t_mask();
    tally_and_finish();
  end
endmodule
